/* rtc_i2c_pkg.sv */
// Shared constants and types for the seconds-counter clock serial port
package rtc_i2c_pkg;
  // Clock rates
  localparam int          CLK_HZ      = 25_000_000;
  localparam int          SCL_STD_HZ  = 100_000;
  localparam int          SCL_FAST_HZ = 400_000;
  // Shortest quarter bit the slave can follow behind its input filter
  localparam int          QTR_MIN     = 8;
  // Pin filter depth and write buffer depth
  localparam int          SYNC_FF     = 3;
  localparam int          BUF_DEPTH   = 2;
  // Fixed slave address and direction bit values
  localparam logic [6:0]  SLV_ADDR    = 7'h68;
  localparam logic        DIR_WR      = 1'b0;
  localparam logic        DIR_RD      = 1'b1;
  // Register map
  localparam logic [2:0]  REG_CNT0    = 3'h0;
  localparam logic [2:0]  REG_CNT3    = 3'h3;
  localparam logic [2:0]  REG_CTRL    = 3'h4;
  localparam logic [2:0]  REG_TRICKLE = 3'h5;
  localparam logic [2:0]  REG_LAST    = 3'h5;
  localparam int          PTR_W       = 3;
  // Reset values
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam logic [7:0]  TRICKLE_RST = 8'h00;
  // Bus master operations
  typedef enum logic [1:0] {OP_START, OP_WR, OP_RD, OP_STOP} op_e;
endpackage

/* rtc_i2c_link_if.sv */
// Two-wire link between the bus master end and the clock slave end
`timescale 1ns/1ps
interface rtc_i2c_link_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;
  // Open drain with pull-ups: a line is low while any driver is enabled
  assign scl = m_scl_oe ? m_scl_o : 1'b1;
  assign sda = (m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o) ? 1'b0 : 1'b1;
  modport master (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe,
                  input scl, input sda);
  modport slave  (output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface

/* pipe_buf.sv */
// Small valid/ready buffer with honest full and empty
`timescale 1ns/1ps
module pipe_buf #(
  parameter int WIDTH = 11,
  parameter int DEPTH = rtc_i2c_pkg::BUF_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  import rtc_i2c_pkg::*;
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2) begin : g_chk
    $error("pipe_buf needs at least two entries");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  // Handshake terms from the fill count
  assign in_ready_o  = cnt_q != (AW + 1)'(DEPTH);
  assign out_valid_o = cnt_q != '0;
  assign out_data_o  = mem_q[rp_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Storage, written only on an accepted push
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= bump(wp_q);
      end
      if (pop) begin
        rp_q <= bump(rp_q);
      end
      cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule

/* rtc_i2c_slave.sv */
// Clock slave end: bus protocol, pointer, byte registers and write stream
`timescale 1ns/1ps
module rtc_i2c_slave (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  rtc_i2c_link_if.slave    bus,
  input  wire logic [31:0] counter_i,
  input  wire logic        pf_i,
  output logic [7:0]       ctrl_o,
  output logic [7:0]       trickle_o,
  output logic             wr_valid_o,
  input  wire logic        wr_ready_i,
  output logic [rtc_i2c_pkg::PTR_W-1:0] wr_addr_o,
  output logic [7:0]       wr_data_o
);
  import rtc_i2c_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_RACK, S_SKIP} state_e;

  state_e             st_q;
  logic [SYNC_FF-1:0] scl_s_q;
  logic [SYNC_FF-1:0] sda_s_q;
  logic               scl_f_q;
  logic               sda_f_q;
  logic               scl_p_q;
  logic               sda_p_q;
  logic               scl_rise;
  logic               scl_fall;
  logic               start_ev;
  logic               stop_ev;
  logic [3:0]         bit_q;
  logic [7:0]         sh_q;
  logic [7:0]         tx_q;
  logic [1:0]         byte_q;
  logic               rd_q;
  logic               ack_q;
  logic               mack_q;
  logic [PTR_W-1:0]   ptr_q;
  logic [7:0]         ctrl_q;
  logic [7:0]         trk_q;
  logic [7:0]         rd_byte;
  logic               byte_done;
  logic               wr_push;
  logic               buf_ready;

  function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
    return (p >= REG_LAST) ? REG_CNT0 : p + PTR_W'(1);
  endfunction

  // Pin filter: the change counts once the last two stages agree
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      scl_s_q <= '1;
      sda_s_q <= '1;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[SYNC_FF-2:0], bus.scl};
      sda_s_q <= {sda_s_q[SYNC_FF-2:0], bus.sda};
      if (scl_s_q[1] == scl_s_q[2]) begin
        scl_f_q <= scl_s_q[2];
      end
      if (sda_s_q[1] == sda_s_q[2]) begin
        sda_f_q <= sda_s_q[2];
      end
      scl_p_q <= scl_f_q;
      sda_p_q <= sda_f_q;
    end
  end

  // Edges and bus conditions; data moving under a high clock is a condition
  assign scl_rise = scl_f_q & ~scl_p_q;
  assign scl_fall = ~scl_f_q & scl_p_q;
  assign start_ev = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
  assign stop_ev  = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;

  // Read mux; counter bytes go out least significant first
  always_comb begin
    rd_byte = 8'h00;
    if (ptr_q <= REG_CNT3) begin
      rd_byte = counter_i[8 * ptr_q +: 8];
    end else if (ptr_q == REG_CTRL) begin
      rd_byte = ctrl_q;
    end else if (ptr_q == REG_TRICKLE) begin
      rd_byte = trk_q;
    end
  end

  // A data byte is stored only when the buffer has room and power is good
  assign byte_done = (st_q == S_RX) & scl_fall & (bit_q == 4'd8);
  assign wr_push   = byte_done & (byte_q == 2'd2) & ~rd_q & ~pf_i & buf_ready;

  // Protocol engine; start and stop override every state
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q   <= S_IDLE;
      bit_q  <= '0;
      sh_q   <= '0;
      tx_q   <= '0;
      byte_q <= '0;
      rd_q   <= DIR_WR;
      ack_q  <= 1'b0;
      mack_q <= 1'b0;
      ptr_q  <= REG_CNT0;
    end else if (start_ev) begin
      st_q   <= S_RX;
      bit_q  <= '0;
      byte_q <= '0;
      ack_q  <= 1'b0;
    end else if (stop_ev) begin
      st_q  <= S_IDLE;
      ack_q <= 1'b0;
    end else begin
      case (st_q)
        S_RX: begin
          if (scl_rise && bit_q != 4'd8) begin
            sh_q  <= {sh_q[6:0], sda_f_q};
            bit_q <= bit_q + 4'd1;
          end else if (byte_done) begin
            st_q <= S_ACK;
            if (byte_q == 2'd0) begin
              if (sh_q[7:1] == SLV_ADDR && !pf_i) begin
                ack_q <= 1'b1;
                rd_q  <= sh_q[0];
              end else begin
                st_q <= S_SKIP;
              end
            end else if (byte_q == 2'd1) begin
              ptr_q <= sh_q[PTR_W-1:0];
              ack_q <= ~pf_i;
            end else begin
              ack_q <= wr_push;
              if (wr_push) begin
                ptr_q <= ptr_next(ptr_q);
              end
            end
            if (byte_q != 2'd2) begin
              byte_q <= byte_q + 2'd1;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            ack_q <= 1'b0;
            bit_q <= '0;
            if (rd_q == DIR_RD) begin
              st_q  <= S_TX;
              tx_q  <= rd_byte;
              ptr_q <= ptr_next(ptr_q);
            end else begin
              st_q <= S_RX;
            end
          end
        end
        S_TX: begin
          // Shift only after the clock has fallen
          if (scl_fall) begin
            if (bit_q == 4'd7) begin
              st_q <= S_RACK;
            end else begin
              tx_q  <= {tx_q[6:0], 1'b0};
              bit_q <= bit_q + 4'd1;
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            mack_q <= ~sda_f_q;
          end else if (scl_fall) begin
            bit_q <= '0;
            if (mack_q) begin
              st_q  <= S_TX;
              tx_q  <= rd_byte;
              ptr_q <= ptr_next(ptr_q);
            end else begin
              st_q <= S_SKIP;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Control and trickle bytes held here; every written byte also streams out
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= CTRL_RST;
      trk_q  <= TRICKLE_RST;
    end else if (wr_push) begin
      if (ptr_q == REG_CTRL) begin
        ctrl_q <= sh_q;
      end
      if (ptr_q == REG_TRICKLE) begin
        trk_q <= sh_q;
      end
    end
  end

  // A full buffer answers with not-acknowledge, so no word is ever dropped
  pipe_buf #(
    .WIDTH (PTR_W + 8),
    .DEPTH (BUF_DEPTH)
  ) u_wbuf (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (wr_push),
    .in_ready_o  (buf_ready),
    .in_data_i   ({ptr_q, sh_q}),
    .out_valid_o (wr_valid_o),
    .out_ready_i (wr_ready_i),
    .out_data_o  ({wr_addr_o, wr_data_o})
  );

  // Drive low only for our acknowledge or a zero data bit
  assign bus.s_sda_o  = 1'b0;
  assign bus.s_sda_oe = ((st_q == S_ACK) & ack_q) | ((st_q == S_TX) & ~tx_q[7]);
  assign ctrl_o       = ctrl_q;
  assign trickle_o    = trk_q;
endmodule

/* rtc_i2c_master.sv */
// Bus master end: runs single-byte writes and reads against the clock slave
`timescale 1ns/1ps
module rtc_i2c_master #(
  parameter int SCL_HZ = rtc_i2c_pkg::SCL_STD_HZ
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  rtc_i2c_link_if.master  bus,
  input  wire logic       cmd_valid_i,
  output logic            cmd_ready_o,
  input  wire logic       cmd_read_i,
  input  wire logic       cmd_keep_ptr_i,
  input  wire logic [7:0] cmd_ptr_i,
  input  wire logic [7:0] cmd_data_i,
  output logic            rsp_valid_o,
  input  wire logic       rsp_ready_i,
  output logic [7:0]      rsp_data_o,
  output logic            rsp_nack_o
);
  import rtc_i2c_pkg::*;
  localparam int QTR = CLK_HZ / (4 * SCL_HZ);

  if (SCL_HZ > SCL_FAST_HZ || QTR < QTR_MIN) begin : g_chk
    $error("rtc_i2c_master bus clock rate not supported");
  end

  typedef enum logic [1:0] {H_IDLE, H_RUN, H_RSP} hstate_e;

  hstate_e            st_q;
  logic [SYNC_FF-1:0] scl_s_q;
  logic [SYNC_FF-1:0] sda_s_q;
  logic               scl_f_q;
  logic               sda_f_q;
  logic [15:0]        div_q;
  logic               tick;
  logic [1:0]         q_q;
  logic [3:0]         bit_q;
  logic [2:0]         step_q;
  logic               rd_q;
  logic [7:0]         ptr_q;
  logic [7:0]         dat_q;
  logic [7:0]         tx_q;
  logic [7:0]         rx_q;
  logic               nack_q;
  logic               scl_oe_q;
  logic               sda_oe_q;
  op_e                op;

  function automatic op_e op_at(input logic [2:0] s, input logic rd);
    if (s == 3'd0 || (rd && s == 3'd3)) begin
      return OP_START;
    end
    if (rd && s == 3'd5) begin
      return OP_RD;
    end
    return (s >= (rd ? 3'd6 : 3'd4)) ? OP_STOP : OP_WR;
  endfunction

  function automatic logic [7:0] byte_at(input logic [2:0] s);
    case (s)
      3'd1:    return {SLV_ADDR, DIR_WR};
      3'd2:    return ptr_q;
      3'd4:    return {SLV_ADDR, DIR_RD};
      default: return dat_q;
    endcase
  endfunction

  assign op = op_at(step_q, rd_q);

  // Pin filter, same scheme as the slave
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      scl_s_q <= '1;
      sda_s_q <= '1;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[SYNC_FF-2:0], bus.scl};
      sda_s_q <= {sda_s_q[SYNC_FF-2:0], bus.sda};
      if (scl_s_q[1] == scl_s_q[2]) begin
        scl_f_q <= scl_s_q[2];
      end
      if (sda_s_q[1] == sda_s_q[2]) begin
        sda_f_q <= sda_s_q[2];
      end
    end
  end

  // Quarter-bit enable; the bus clock is built from four of them
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || st_q != H_RUN) begin
      div_q <= '0;
    end else begin
      div_q <= tick ? '0 : div_q + 16'd1;
    end
  end
  assign tick = (div_q == 16'(QTR - 1));

  // Sequencer; a refused byte skips straight to the stop
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q     <= H_IDLE;
      q_q      <= '0;
      bit_q    <= '0;
      step_q   <= '0;
      rd_q     <= 1'b0;
      ptr_q    <= '0;
      dat_q    <= '0;
      tx_q     <= '0;
      rx_q     <= '0;
      nack_q   <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      case (st_q)
        H_IDLE: begin
          if (cmd_valid_i && cmd_ready_o) begin
            st_q   <= H_RUN;
            rd_q   <= cmd_read_i;
            ptr_q  <= cmd_ptr_i;
            dat_q  <= cmd_data_i;
            nack_q <= 1'b0;
            q_q    <= '0;
            bit_q  <= '0;
            step_q <= (cmd_read_i && cmd_keep_ptr_i) ? 3'd3 : 3'd0;
          end
        end
        H_RUN: begin
          if (tick) begin
            q_q <= q_q + 2'd1;
            case (op)
              OP_START: begin
                if (q_q == 2'd0) sda_oe_q <= 1'b0;
                if (q_q == 2'd1) scl_oe_q <= 1'b0;
                if (q_q == 2'd2) sda_oe_q <= 1'b1;
                if (q_q == 2'd3) begin
                  scl_oe_q <= 1'b1;
                  step_q   <= step_q + 3'd1;
                  tx_q     <= byte_at(step_q + 3'd1);
                end
              end
              OP_STOP: begin
                if (q_q == 2'd0) sda_oe_q <= 1'b1;
                if (q_q == 2'd1) scl_oe_q <= 1'b0;
                if (q_q == 2'd2) sda_oe_q <= 1'b0;
                if (q_q == 2'd3) st_q <= H_RSP;
              end
              default: begin
                if (q_q == 2'd0) begin
                  sda_oe_q <= (op == OP_WR) && (bit_q != 4'd8) && !tx_q[7];
                end
                if (q_q == 2'd1) scl_oe_q <= 1'b0;
                if (q_q == 2'd2) begin
                  if (bit_q != 4'd8) begin
                    rx_q <= {rx_q[6:0], sda_f_q};
                  end else if (op == OP_WR && sda_f_q) begin
                    nack_q <= 1'b1;
                  end
                end
                if (q_q == 2'd3) begin
                  scl_oe_q <= 1'b1;
                  tx_q     <= {tx_q[6:0], 1'b0};
                  bit_q    <= bit_q + 4'd1;
                  if (bit_q == 4'd8) begin
                    bit_q  <= '0;
                    step_q <= nack_q ? (rd_q ? 3'd6 : 3'd4) : step_q + 3'd1;
                    tx_q   <= byte_at(step_q + 3'd1);
                  end
                end
              end
            endcase
          end
        end
        H_RSP: begin
          if (rsp_ready_i) st_q <= H_IDLE;
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // New command only while both lines rest high
  assign cmd_ready_o  = (st_q == H_IDLE) & scl_f_q & sda_f_q;
  assign rsp_valid_o  = (st_q == H_RSP);
  assign rsp_data_o   = rx_q;
  assign rsp_nack_o   = nack_q;
  assign bus.m_scl_o  = 1'b0;
  assign bus.m_scl_oe = scl_oe_q;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = sda_oe_q;
endmodule

/* rtc_i2c_link_sva.sv */
// Protocol checker for the link between the master and slave ends
`timescale 1ns/1ps
module rtc_i2c_link_sva (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic s_sda_oe,
  input  wire logic pf_i
);
  import rtc_i2c_pkg::*;
  logic       scl_q;
  logic       sda_q;
  logic       rd_q;
  logic       ok_q;
  logic       nack_q;
  logic [3:0] cnt_q;
  logic [1:0] byte_q;
  logic [7:0] sh_q;
  logic       rise;
  logic       cond;
  logic       ack_slot;
  // Line edges against the previous clock; start and stop both restart the count
  assign rise     = scl & ~scl_q;
  assign cond     = scl & scl_q & (sda != sda_q);
  assign ack_slot = rise & (cnt_q == 4'h8);
  always_ff @(posedge clk_i) begin
    scl_q <= scl;
    sda_q <= sda;
  end
  // Bit and byte position within the current transfer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || cond) begin
      cnt_q  <= 4'h0;
      byte_q <= 2'h0;
    end else if (ack_slot) begin
      cnt_q  <= 4'h0;
      byte_q <= (byte_q == 2'h3) ? byte_q : byte_q + 2'h1;
    end else if (rise) begin
      cnt_q <= cnt_q + 4'h1;
      sh_q  <= {sh_q[6:0], sda};
    end
  end
  // Direction, address match and a read ended by the master
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || cond) begin
      rd_q   <= 1'h0;
      ok_q   <= 1'h0;
      nack_q <= 1'h0;
    end else if (ack_slot && byte_q == 2'h0) begin
      rd_q <= sh_q[0];
      ok_q <= (sh_q[7:1] == SLV_ADDR);
    end else if (ack_slot && rd_q && sda) begin
      nack_q <= 1'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_slv_edge;
    $changed(s_sda_oe) |-> !scl && !$past(scl);
  endproperty
  a_slv_edge: assert property (p_slv_edge)
    else $error("slave moved data with clock high");
  property p_ack_hold;
    s_sda_oe && rise |-> (s_sda_oe && !sda) [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("slave low level not held through clock high");
  property p_addr_ack;
    ack_slot && byte_q == 2'h0 && sh_q[7:1] == SLV_ADDR && !pf_i |-> s_sda_oe && !sda;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");
  property p_ptr_ack;
    ack_slot && byte_q == 2'h1 && ok_q && !rd_q && !pf_i |-> s_sda_oe;
  endproperty
  a_ptr_ack: assert property (p_ptr_ack)
    else $error("pointer byte not acknowledged");
  property p_pf_quiet;
    pf_i && ack_slot |-> !s_sda_oe;
  endproperty
  a_pf_quiet: assert property (p_pf_quiet)
    else $error("byte acknowledged during power fail");
  property p_rd_release;
    nack_q |-> !s_sda_oe;
  endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("slave drove data after read not-acknowledge");
  property p_mst_nack;
    ack_slot && rd_q && byte_q == 2'h1 |-> sda;
  endproperty
  a_mst_nack: assert property (p_mst_nack)
    else $error("master acknowledged its last read byte");
  property p_scl_high;
    $rose(scl) |-> scl [*8];
  endproperty
  a_scl_high: assert property (p_scl_high)
    else $error("clock high pulse too short");
endmodule

/* counter_rtc_i2c_slave_port_tb.sv */
// Self-checking bench: joined master and slave, plus a hand-driven slow link
`timescale 1ns/1ps
module counter_rtc_i2c_slave_port_tb;
  import rtc_i2c_pkg::*;
  localparam int          QB  = 62;
  localparam logic [31:0] CNT = 32'h89AB_CDEF;
  logic        clk_i, rst_n_i, cmd_valid, cmd_ready, cmd_read, cmd_keep;
  logic        rsp_valid, rsp_ready, rsp_nack, pf, wr_valid, wr_ready;
  logic [7:0]  cmd_ptr, cmd_data, rsp_data, ctrl, trickle, ctrl2, wr_data, got_data;
  logic [2:0]  wr_addr;
  logic        got_nack;
  logic [10:0] wq[$];
  int          num_errors, checks_done;
  rtc_i2c_link_if lk();
  rtc_i2c_link_if lk2();
  // Slow link is driven by hand; data values stay open drain
  assign lk2.m_scl_o = 1'h0;
  assign lk2.m_sda_o = 1'h0;
  rtc_i2c_master #(.SCL_HZ(SCL_FAST_HZ)) rtc_i2c_master_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .bus(lk), .cmd_valid_i(cmd_valid),
    .cmd_ready_o(cmd_ready), .cmd_read_i(cmd_read), .cmd_keep_ptr_i(cmd_keep),
    .cmd_ptr_i(cmd_ptr), .cmd_data_i(cmd_data), .rsp_valid_o(rsp_valid),
    .rsp_ready_i(rsp_ready), .rsp_data_o(rsp_data), .rsp_nack_o(rsp_nack));
  rtc_i2c_slave rtc_i2c_slave_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .bus(lk), .counter_i(CNT), .pf_i(pf),
    .ctrl_o(ctrl), .trickle_o(trickle), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data));
  rtc_i2c_slave rtc_i2c_slave_inst2 (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .bus(lk2), .counter_i(CNT), .pf_i(1'h0),
    .ctrl_o(ctrl2), .trickle_o(), .wr_valid_o(), .wr_ready_i(1'h1),
    .wr_addr_o(), .wr_data_o());
  rtc_i2c_link_sva rtc_i2c_link_sva_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .scl(lk.scl), .sda(lk.sda),
    .s_sda_oe(lk.s_sda_oe), .pf_i(pf));
  // Collect every word the write stream hands over
  always @(posedge clk_i) begin
    if (rst_n_i && wr_valid && wr_ready) begin
      wq.push_back({wr_addr, wr_data});
    end
  end
  task automatic test_done;
    if (num_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic timeout;
    num_errors++;
    $display("[FAIL] %0t wait ran out", $time);
    test_done();
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t byte %h, want %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t bit %b, want %b", $time, got, exp);
    end
  endtask
  task automatic check_word(input logic [10:0] got, input logic [10:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t word %h, want %h", $time, got, exp);
    end
  endtask
  // One command: ready seen at a falling edge is taken at the next rising edge
  task automatic cmd(input logic rd, input logic keep, input logic [7:0] p, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cmd_valid <= 1'h1;
    cmd_read  <= rd;
    cmd_keep  <= keep;
    cmd_ptr   <= p;
    cmd_data  <= d;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (cmd_ready !== 1'h1 && n < 200);
    if (cmd_ready !== 1'h1) timeout();
    @(posedge clk_i);
    cmd_valid <= 1'h0;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (rsp_valid !== 1'h1 && n < 20000);
    if (rsp_valid !== 1'h1) timeout();
    got_data = rsp_data;
    got_nack = rsp_nack;
    @(posedge clk_i);
    rsp_ready <= 1'h1;
    @(posedge clk_i);
    rsp_ready <= 1'h0;
  endtask
  // One quarter bit on the slow link; enable high pulls the line low
  task automatic qtr(input logic scl_lo, input logic sda_lo);
    @(posedge clk_i);
    lk2.m_scl_oe <= scl_lo;
    lk2.m_sda_oe <= sda_lo;
    repeat (QB - 1) @(posedge clk_i);
  endtask
  // Clock keeps its level here, so an idle bus sees no stray pulse
  task automatic bb_start;
    qtr(lk2.m_scl_oe, 1'h0);
    qtr(1'h0, 1'h0);
    qtr(1'h0, 1'h1);
    qtr(1'h1, 1'h1);
  endtask
  // Sampled mid clock-high, where the line must be steady
  task automatic bb_bit(input logic b, output logic s);
    qtr(1'h1, ~b);
    qtr(1'h0, ~b);
    s = lk2.sda;
    qtr(1'h0, ~b);
    qtr(1'h1, ~b);
  endtask
  task automatic bb_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bb_bit(v[i], s);
    end
    bb_bit(1'h1, ack);
  endtask
  task automatic t_write_read;
    wq.delete();
    cmd(1'h0, 1'h0, 8'h04, 8'hA5);
    check_bit(got_nack, 1'h0);
    cmd(1'h0, 1'h0, 8'h05, 8'h5A);
    check_byte(ctrl, 8'hA5);
    check_byte(trickle, 8'h5A);
    cmd(1'h1, 1'h0, 8'h04, 8'h00);
    check_byte(got_data, 8'hA5);
    cmd(1'h1, 1'h1, 8'h00, 8'h00);
    check_byte(got_data, 8'h5A);
    cmd(1'h1, 1'h1, 8'h00, 8'h00);
    check_byte(got_data, CNT[7:0]);
    for (int k = 1; k < 4; k++) begin
      cmd(1'h1, 1'h0, 8'(k), 8'h00);
      check_byte(got_data, CNT[8*k +: 8]);
    end
    check_bit(lk.scl & lk.sda, 1'h1);
    check_word(wq[0], {REG_CTRL, 8'hA5});
    check_word(wq[1], {REG_TRICKLE, 8'h5A});
  endtask
  // Receiver stalls: two words wait, the third byte is refused
  task automatic t_stall;
    int n;
    wq.delete();
    @(posedge clk_i);
    wr_ready <= 1'h0;
    cmd(1'h0, 1'h0, 8'h04, 8'h11);
    check_bit(got_nack, 1'h0);
    cmd(1'h0, 1'h0, 8'h04, 8'h22);
    check_bit(got_nack, 1'h0);
    cmd(1'h0, 1'h0, 8'h04, 8'h33);
    check_bit(got_nack, 1'h1);
    check_byte(ctrl, 8'h22);
    @(posedge clk_i);
    wr_ready <= 1'h1;
    n = 0;
    while (wq.size() < 2 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (wq.size() < 2) timeout();
    check_word(wq[0], {REG_CTRL, 8'h11});
    check_word(wq[1], {REG_CTRL, 8'h22});
  endtask
  task automatic t_pf;
    @(posedge clk_i);
    pf <= 1'h1;
    cmd(1'h0, 1'h0, 8'h05, 8'h77);
    check_bit(got_nack, 1'h1);
    @(posedge clk_i);
    pf <= 1'h0;
    check_byte(trickle, 8'h5A);
  endtask
  // Slow link: foreign address ignored, then a repeated start with our own
  task automatic t_foreign;
    logic a;
    bb_start();
    bb_byte(8'hA0, a);
    check_bit(a, 1'h1);
    bb_start();
    bb_byte({SLV_ADDR, DIR_WR}, a);
    check_bit(a, 1'h0);
    bb_byte(8'h04, a);
    check_bit(a, 1'h0);
    bb_byte(8'h3C, a);
    check_bit(a, 1'h0);
    qtr(1'h1, 1'h1);
    qtr(1'h0, 1'h1);
    qtr(1'h0, 1'h0);
    check_byte(ctrl2, 8'h3C);
  endtask
  initial begin
    clk_i = 1'h0;
    forever #20 clk_i = ~clk_i;
  end
  // Main sequence; every input has a value at time zero
  initial begin
    num_errors = 0;
    checks_done = 0;
    rst_n_i = 1'h0;
    cmd_valid = 1'h0;
    cmd_read = 1'h0;
    cmd_keep = 1'h0;
    cmd_ptr = 8'h00;
    cmd_data = 8'h00;
    rsp_ready = 1'h0;
    pf = 1'h0;
    wr_ready = 1'h1;
    lk2.m_scl_oe = 1'h0;
    lk2.m_sda_oe = 1'h0;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'h1;
    repeat (8) @(posedge clk_i);
    t_write_read();
    t_stall();
    t_pf();
    t_foreign();
    test_done();
  end
endmodule
